// ===== hprkc_top.v
// keypad driven power and reset sequencer for a host motherboard
`timescale 1ns/1ps
`default_nettype none
`include "hprkc_consts.vh"

module hprkc_top #(
    parameter [31:0] TICK_CYC = `HPRKC_TICK_CYC
) (
    // clock, reset, enable
    input  wire        CLK_I,
    input  wire        RST_B_I,
    input  wire        CE_I,
    // configuration
    input  wire        CFG_PON_EN_I,
    input  wire        CFG_HOFF_EN_I,
    input  wire        CFG_HRST_EN_I,
    input  wire        CFG_LCD_OFF_I,
    input  wire        CFG_PWR_INV_I,
    input  wire        CFG_RST_INV_I,
    input  wire [7:0]  CFG_PULSE_I,
    input  wire [7:0]  CFG_SENSE_SRC_I,
    // host sense and keys
    input  wire        SENSE_CONN_I,
    input  wire        SENSE_GPIO_I,
    input  wire        KEY_CONFIRM_I,
    input  wire        KEY_CANCEL_I,
    // power switch pin
    output reg         PWR_CTL_O,
    output reg         PWR_CTL_OE_O,
    // reset switch pin
    output reg         RST_CTL_O,
    output reg         RST_CTL_OE_O,
    // status
    output reg         DISP_BLANK_O,
    output reg         SELF_RESTART_O,
    output reg         HOST_ON_O,
    output reg         BUSY_O
);

    // ****************************************************************
    // timing in ticks
    // ****************************************************************
    // full width first so the byte slices below cut on purpose
    localparam [31:0] PON_HOLD_W  = `HPRKC_MS2TICK_UP(`HPRKC_PON_HOLD_MS);
    localparam [31:0] HOFF_HOLD_W = `HPRKC_MS2TICK_UP(`HPRKC_HOFF_HOLD_MS);
    localparam [31:0] HRST_HOLD_W = `HPRKC_MS2TICK_UP(`HPRKC_HRST_HOLD_MS);
    localparam [31:0] HRST_LEN_W  = `HPRKC_MS2TICK_UP(`HPRKC_HRST_PULSE_MS);
    localparam [31:0] HOFF_EXT_W  = `HPRKC_MS2TICK_DN(`HPRKC_HOFF_EXT_MS);
    localparam [31:0] PULSE_DEF_W = `HPRKC_MS2TICK_UP(`HPRKC_PULSE_DEF_MS);

    localparam [7:0]  PON_HOLD    = PON_HOLD_W[7:0];
    localparam [7:0]  HOFF_HOLD   = HOFF_HOLD_W[7:0];
    localparam [7:0]  HRST_HOLD   = HRST_HOLD_W[7:0];
    localparam [7:0]  HRST_LEN    = HRST_LEN_W[7:0];
    localparam [7:0]  HOFF_EXT    = HOFF_EXT_W[7:0];
    localparam [7:0]  PULSE_DEF   = PULSE_DEF_W[7:0];

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [3:0] S_IDLE     = 4'H0;
    localparam [3:0] S_HOLD_ON  = 4'H1;
    localparam [3:0] S_HOLD_OFF = 4'H2;
    localparam [3:0] S_HOLD_RST = 4'H3;
    localparam [3:0] S_PWR_ON   = 4'H4;
    localparam [3:0] S_PWR_OFF  = 4'H5;
    localparam [3:0] S_PWR_EXT  = 4'H6;
    localparam [3:0] S_RST      = 4'H7;
    localparam [3:0] S_WAIT     = 4'H8;

    // pin level while driving: low unless inverted
    function drive_lvl;
        input inv;
        begin
            drive_lvl = inv ? 1'B1 : 1'B0;
        end
    endfunction

    // a hold ends early on key release, sense change or enable drop
    function hold_drop;
        input key;
        input sense_ok;
        input en;
        begin
            hold_drop = !key || !sense_ok || !en;
        end
    endfunction

    reg  [3:0] state_r;
    reg  [3:0] state_nxt;
    reg        restart_nxt;
    wire       tick;
    wire [7:0] cnt;
    wire       clr;
    wire       sense;
    wire [7:0] pw_ticks;
    wire       pwr_drv;
    wire       rst_drv;

    // ****************************************************************
    // sense select and pulse width decode
    // ****************************************************************
    // sense source select
    assign sense = (CFG_SENSE_SRC_I == `HPRKC_SENSE_CONN) ? SENSE_CONN_I
                                                          : SENSE_GPIO_I;

    assign pw_ticks = (CFG_PULSE_I == `HPRKC_PULSE_USE_DEF) ? PULSE_DEF
                                                            : CFG_PULSE_I;

    // every state change restarts the time base and counter
    assign clr = (state_nxt != state_r);

    hprkc_tick #(
        .CYC     (TICK_CYC)
    ) u_tick (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .ce_i    (CE_I),
        .clr_i   (clr),
        .tick_o  (tick)
    );

    hprkc_cnt u_cnt (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .ce_i    (CE_I),
        .clr_i   (clr),
        .tick_i  (tick),
        .cnt_o   (cnt)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always @* begin
        state_nxt   = state_r;
        restart_nxt = 1'B0;
        case (state_r)
            S_IDLE: begin
                if (CFG_PON_EN_I && !sense && KEY_CONFIRM_I) begin
                    state_nxt = S_HOLD_ON;
                end else if (CFG_HRST_EN_I && sense && KEY_CONFIRM_I) begin
                    state_nxt = S_HOLD_RST;
                end else if (CFG_HOFF_EN_I && sense && KEY_CANCEL_I) begin
                    state_nxt = S_HOLD_OFF;
                end
            end
            S_HOLD_ON: begin
                if (hold_drop(KEY_CONFIRM_I, !sense, CFG_PON_EN_I)) begin
                    state_nxt = S_IDLE;
                end else if (cnt >= PON_HOLD) begin
                    state_nxt = S_PWR_ON;
                end
            end
            S_HOLD_OFF: begin
                if (hold_drop(KEY_CANCEL_I, sense, CFG_HOFF_EN_I)) begin
                    state_nxt = S_IDLE;
                end else if (cnt >= HOFF_HOLD) begin
                    state_nxt = S_PWR_OFF;
                end
            end
            S_HOLD_RST: begin
                if (hold_drop(KEY_CONFIRM_I, sense, CFG_HRST_EN_I)) begin
                    state_nxt = S_IDLE;
                end else if (cnt >= HRST_HOLD) begin
                    state_nxt = S_RST;
                end
            end
            S_PWR_ON: begin
                if (cnt >= pw_ticks) begin
                    state_nxt = S_WAIT;
                end
            end
            S_PWR_OFF: begin
                if (cnt >= pw_ticks) begin
                    state_nxt = KEY_CANCEL_I ? S_PWR_EXT : S_WAIT;
                end
            end
            S_PWR_EXT: begin
                if (!KEY_CANCEL_I || (cnt >= HOFF_EXT)) begin
                    state_nxt = S_WAIT;
                end
            end
            S_RST: begin
                if (cnt >= HRST_LEN) begin
                    state_nxt   = S_WAIT;
                    restart_nxt = 1'B1;
                end
            end
            // wait for all keys up so one hold never fires twice
            S_WAIT: begin
                if (!KEY_CONFIRM_I && !KEY_CANCEL_I) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // pin drive decode
    // ****************************************************************
    // power pin driven only while acting
    assign pwr_drv = (state_nxt == S_PWR_ON) || (state_nxt == S_PWR_OFF) ||
                     (state_nxt == S_PWR_EXT);
    // reset pin driven only while resetting
    assign rst_drv = (state_nxt == S_RST);

    // index 0 is the power pin, index 1 the reset pin
    wire [1:0] pin_drv;
    wire [1:0] pin_inv;
    wire [1:0] pin_lvl_nxt;
    genvar     g;

    assign pin_drv = {rst_drv, pwr_drv};
    assign pin_inv = {CFG_RST_INV_I, CFG_PWR_INV_I};

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pin
            // idle level stays 0 so a floating pin shows no stale drive
            assign pin_lvl_nxt[g] = pin_drv[g] & drive_lvl(pin_inv[g]);
        end
    endgenerate

    // ****************************************************************
    // state register
    // ****************************************************************
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            state_r <= S_IDLE;
        end else if (CE_I) begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // switch pins
    // ****************************************************************
    // registered from the next state so pins move with the state
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            PWR_CTL_O    <= 1'B0;
            PWR_CTL_OE_O <= 1'B0;
            RST_CTL_O    <= 1'B0;
            RST_CTL_OE_O <= 1'B0;
        end else if (CE_I) begin
            PWR_CTL_OE_O <= pwr_drv;
            PWR_CTL_O    <= pin_lvl_nxt[0];
            RST_CTL_OE_O <= rst_drv;
            RST_CTL_O    <= pin_lvl_nxt[1];
        end
    end

    // ****************************************************************
    // status
    // ****************************************************************
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            DISP_BLANK_O   <= 1'B0;
            SELF_RESTART_O <= 1'B0;
            HOST_ON_O      <= 1'B0;
            BUSY_O         <= 1'B0;
        end else if (CE_I) begin
            DISP_BLANK_O   <= CFG_LCD_OFF_I & ~sense;
            SELF_RESTART_O <= restart_nxt;
            HOST_ON_O      <= sense;
            BUSY_O         <= (state_nxt != S_IDLE);
        end
    end

endmodule // hprkc_top

`default_nettype wire

// ===== hprkc_consts.vh
// constants for the host power and reset keypad sequencer
`ifndef HPRKC_CONSTS_VH
`define HPRKC_CONSTS_VH

// ****************************************************************
// clock and time base
// ****************************************************************
`define HPRKC_CLK_MHZ        250
// one time-base tick is 1/32 s, so a pulse byte of 16 is half a second
`define HPRKC_TICK_US        31250
`define HPRKC_TICK_CYC       (`HPRKC_TICK_US * `HPRKC_CLK_MHZ)

// ****************************************************************
// documented times in milliseconds
// ****************************************************************
`define HPRKC_PON_HOLD_MS    250
`define HPRKC_HOFF_HOLD_MS   4000
`define HPRKC_HRST_HOLD_MS   4000
`define HPRKC_HRST_PULSE_MS  1000
`define HPRKC_HOFF_EXT_MS    5000
`define HPRKC_PULSE_DEF_MS   1000

// least times round up, longest times round down
`define HPRKC_MS2TICK_UP(ms) \
    ((((ms) * 1000) + `HPRKC_TICK_US - 1) / `HPRKC_TICK_US)
`define HPRKC_MS2TICK_DN(ms) (((ms) * 1000) / `HPRKC_TICK_US)

// ****************************************************************
// configuration byte codes
// ****************************************************************
`define HPRKC_SENSE_CONN     8'H01
`define HPRKC_PULSE_USE_DEF  8'H00

`endif

// ===== hprkc_tick.v
// time-base prescaler producing one-cycle ticks, restartable
`timescale 1ns/1ps
`default_nettype none

module hprkc_tick #(
    parameter [31:0] CYC = 32'H0077_3594
) (
    // clock and control
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        ce_i,
    input  wire        clr_i,
    // tick out
    output reg         tick_o
);

    localparam [31:0] LAST = CYC - 32'H0000_0001;

    reg [31:0] cnt_r;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_r  <= 32'H0000_0000;
            tick_o <= 1'B0;
        end else if (ce_i) begin
            // restart keeps every interval a whole tick from state entry
            if (clr_i) begin
                cnt_r  <= 32'H0000_0000;
                tick_o <= 1'B0;
            end else if (cnt_r >= LAST) begin
                cnt_r  <= 32'H0000_0000;
                tick_o <= 1'B1;
            end else begin
                cnt_r  <= cnt_r + 32'H0000_0001;
                tick_o <= 1'B0;
            end
        end
    end

endmodule // hprkc_tick

`default_nettype wire

// ===== hprkc_cnt.v
// saturating tick counter used for key holds and output pulses
`timescale 1ns/1ps
`default_nettype none

module hprkc_cnt (
    // clock and control
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        ce_i,
    input  wire        clr_i,
    input  wire        tick_i,
    // count out
    output reg  [7:0]  cnt_o
);

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_o <= 8'H00;
        end else if (ce_i) begin
            if (clr_i) begin
                cnt_o <= 8'H00;
            // saturate so a long hold never wraps into a false match
            end else if (tick_i && (cnt_o != 8'HFF)) begin
                cnt_o <= cnt_o + 8'H01;
            end
        end
    end

endmodule // hprkc_cnt

`default_nettype wire

// ===== hprkc_chk_sva.sv
// assertion checker for the keypad power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module hprkc_chk #(
    parameter [31:0] TICK_CYC = 32'H0000_0004
) (
    // clock, reset and enable
    input wire logic       CLK_I,
    input wire logic       RST_B_I,
    input wire logic       CE_I,
    // configuration
    input wire logic       CFG_PON_EN_I,
    input wire logic       CFG_HOFF_EN_I,
    input wire logic       CFG_HRST_EN_I,
    input wire logic       CFG_LCD_OFF_I,
    input wire logic       CFG_PWR_INV_I,
    input wire logic       CFG_RST_INV_I,
    input wire logic [7:0] CFG_SENSE_SRC_I,
    // sense and keys
    input wire logic       SENSE_CONN_I,
    input wire logic       SENSE_GPIO_I,
    input wire logic       KEY_CONFIRM_I,
    input wire logic       KEY_CANCEL_I,
    // outputs watched
    input wire logic       PWR_CTL_O,
    input wire logic       PWR_CTL_OE_O,
    input wire logic       RST_CTL_O,
    input wire logic       RST_CTL_OE_O,
    input wire logic       DISP_BLANK_O,
    input wire logic       SELF_RESTART_O,
    input wire logic       HOST_ON_O
);
    localparam int PON = 8 * TICK_CYC;
    localparam int HLD = 128 * TICK_CYC;
    localparam int RPW = 32 * TICK_CYC - 2;
    // consecutive key hold lengths, so a broken hold cannot pass
    logic [15:0] cf_r;
    logic [15:0] cn_r;
    always_ff @(posedge CLK_I) begin
        cf_r <= (!RST_B_I || !KEY_CONFIRM_I) ? 16'H0000 : cf_r + 16'H0001;
        cn_r <= (!RST_B_I || !KEY_CANCEL_I) ? 16'H0000 : cn_r + 16'H0001;
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_pwr_pin_level: assert property (
        PWR_CTL_O == (PWR_CTL_OE_O & CFG_PWR_INV_I)) else $error("power pin");
    a_rst_pin_level: assert property (
        RST_CTL_O == (RST_CTL_OE_O & CFG_RST_INV_I)) else $error("reset pin");
    a_restart_pulse: assert property ($past(RST_B_I && CE_I) |->
        SELF_RESTART_O == $fell(RST_CTL_OE_O)) else $error("restart pulse");
    a_blank_follow: assert property ($past(RST_B_I && CE_I) |->
        DISP_BLANK_O == ($past(CFG_LCD_OFF_I) & !HOST_ON_O))
        else $error("display blank");
    a_sense_select: assert property ($past(RST_B_I && CE_I) |->
        HOST_ON_O == $past(CFG_SENSE_SRC_I == 8'H01 ? SENSE_CONN_I
        : SENSE_GPIO_I)) else $error("sense source");
    a_pon_hold_en: assert property (
        $rose(PWR_CTL_OE_O) && !HOST_ON_O
        |-> CFG_PON_EN_I && cf_r >= PON) else $error("power-on hold");
    a_off_hold_en: assert property (
        $rose(PWR_CTL_OE_O) && HOST_ON_O
        |-> CFG_HOFF_EN_I && cn_r >= HLD) else $error("power-off hold");
    a_rst_hold_en: assert property (
        $rose(RST_CTL_OE_O) |-> HOST_ON_O && CFG_HRST_EN_I
        && cf_r >= HLD) else $error("reset hold");
    a_rst_width: assert property ($rose(RST_CTL_OE_O) |->
        ##RPW RST_CTL_OE_O ##[1:4] !RST_CTL_OE_O) else $error("reset width");
    // a frozen block must keep both pin enables exactly as they were
    a_freeze_hold: assert property (!CE_I |=>
        $stable(PWR_CTL_OE_O) && $stable(RST_CTL_OE_O)) else $error("freeze");
    c_pon: cover property ($rose(PWR_CTL_OE_O) && !HOST_ON_O);
    c_off: cover property ($rose(PWR_CTL_OE_O) && HOST_ON_O);
    c_rst: cover property (SELF_RESTART_O);
    c_frz: cover property (!CE_I && PWR_CTL_OE_O);
endmodule // hprkc_chk
bind hprkc_top hprkc_chk #(.TICK_CYC(TICK_CYC)) u_chk (.*);
`default_nettype wire

// ===== hprkc_mobo.sv
// host board model: measures switch pulses and toggles its supply
`timescale 1ns/1ps
`default_nettype none
module hprkc_mobo (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // switch pins, driven while enable high
    input  wire logic        pwr_oe_i,
    input  wire logic        rst_oe_i,
    // host state and measured pulses
    output var  logic        host_on_o,
    output var  logic [15:0] pwr_len_o,
    output var  logic [15:0] pwr_cnt_o,
    output var  logic [15:0] rst_len_o
);
    logic [15:0] pr_r;
    logic [15:0] rr_r;
    // pins kept on their switch function
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            {host_on_o, pwr_len_o, pwr_cnt_o, rst_len_o} <= 49'H0;
            pr_r <= 16'H0000;
            rr_r <= 16'H0000;
        end else begin
            pr_r <= pwr_oe_i ? pr_r + 16'H0001 : 16'H0000;
            rr_r <= rst_oe_i ? rr_r + 16'H0001 : 16'H0000;
            // a power press toggles the supply as it ends
            if (!pwr_oe_i && pr_r != 16'H0000) begin
                pwr_len_o <= pr_r;
                pwr_cnt_o <= pwr_cnt_o + 16'H0001;
                host_on_o <= !host_on_o;
            end
            if (!rst_oe_i && rr_r != 16'H0000) rst_len_o <= rr_r;
        end
    end
endmodule // hprkc_mobo
`default_nettype wire

// ===== hprkc_top_bench.sv
// self-checking bench for the keypad power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module hprkc_top_bench;
    logic        clk = 1'b0, rst_b = 1'b0, pon = 1'b0, hoff = 1'b1;
    logic        hrst = 1'b1, lcd = 1'b0, pinv = 1'b0, rinv = 1'b0;
    logic        kc = 1'b0, kx = 1'b0, ce = 1'b1;
    logic [7:0]  pw = 8'H10, src = 8'H01;
    logic [31:0] rnd = 32'H0000_308C;
    wire         host, pwr_oe, rst_oe, busy, rs_o;
    wire  [15:0] plen, pcnt, rlen;
    int          bad_count = 0, samples_checked = 0, cyc = 0, rs_n = 0, frz = 0;
    hprkc_top #(.TICK_CYC(32'H0000_0004)) DUT (
        .CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
        .CFG_PON_EN_I(pon), .CFG_HOFF_EN_I(hoff), .CFG_HRST_EN_I(hrst),
        .CFG_LCD_OFF_I(lcd), .CFG_PWR_INV_I(pinv), .CFG_RST_INV_I(rinv),
        .CFG_PULSE_I(pw), .CFG_SENSE_SRC_I(src),
        .SENSE_CONN_I(src == 8'H01 ? host : !host),
        .SENSE_GPIO_I(src == 8'H01 ? !host : host),
        .KEY_CONFIRM_I(kc), .KEY_CANCEL_I(kx),
        .PWR_CTL_O(), .PWR_CTL_OE_O(pwr_oe),
        .RST_CTL_O(), .RST_CTL_OE_O(rst_oe),
        .DISP_BLANK_O(), .SELF_RESTART_O(rs_o), .HOST_ON_O(), .BUSY_O(busy));
    hprkc_mobo u_mobo (.clk_i(clk), .rst_b_i(rst_b), .pwr_oe_i(pwr_oe),
        .rst_oe_i(rst_oe), .host_on_o(host), .pwr_len_o(plen),
        .pwr_cnt_o(pcnt), .rst_len_o(rlen));
    initial forever #2 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // pulse cycles: width byte (0 = 32 ticks) plus extension, 4 cycles a tick
    function automatic int exp_len(input logic [7:0] p, input int ext);
        return ((p == 8'H00 ? 32 : int'(p)) + ext) * 4 + 1;
    endfunction
    task close_out;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] got, input int exp, input int tol);
        samples_checked++;
        if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // hold a key for a count, or until a pin is driven, then release
    task press(input logic conf, input int hold, input int extra);
        int n;
        @(negedge clk);
        rnd = lfsr(rnd);
        lcd = rnd[3];
        kc = conf;
        kx = !conf;
        n = 0;
        while (hold == 0 ? !(pwr_oe | rst_oe) && n < 1000 : n < hold) begin
            @(negedge clk);
            n++;
        end
        // freeze mid-pulse: the pulse must stretch by the frozen cycles
        if (frz > 0) begin
            ce = 1'b0;
            repeat (frz) @(negedge clk);
            ce = 1'b1;
        end
        repeat (extra) @(negedge clk);
        kc = 1'b0;
        kx = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (rs_o === 1'b1) rs_n++;
        if (cyc == 12000) begin
            bad_count++;
            close_out;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        press(1'b1, 60, 0);
        chk(pcnt, 0, 0);
        pon = 1'b1;
        press(1'b1, 20, 0);
        chk(pcnt, 0, 0);
        $display("test refused holds done");
        pinv = rnd[1];
        frz = 9;
        press(1'b1, 0, 0);
        chk(plen, exp_len(pw, 0) + frz, 2);
        frz = 0;
        rinv = rnd[2];
        press(1'b1, 0, 0);
        chk(rlen, 129, 2);
        chk(rs_n[15:0], 1, 0);
        $display("test power-on and reset done");
        src = 8'H00;
        pw = 8'H00;
        press(1'b0, 0, 0);
        chk(plen, exp_len(pw, 0), 2);
        rnd = lfsr(rnd);
        pw = {3'H0, rnd[4:0]} | 8'H01;
        src = 8'H01;
        pinv = rnd[6];
        press(1'b1, 0, 0);
        chk(plen, exp_len(pw, 0), 2);
        press(1'b0, 0, 2000);
        chk(plen, exp_len(pw, 160), 3);
        chk(pcnt, 4, 0);
        $display("test power-off done");
        close_out;
    end
endmodule // hprkc_top_bench
`default_nettype wire
